//--- hdl/sync_serial_pkg.sv
package sync_serial_pkg;

////////////////////////////////////////////////////////////////////////
// register byte addresses
localparam logic [11:0] OFF_STATUS = 12'h094;
localparam logic [11:0] OFF_BUF = 12'h098;
localparam logic [11:0] OFF_CTRL = 12'h09c;
localparam logic [11:0] OFF_CTRL2 = 12'h0a0;
localparam logic [11:0] OFF_ADDR = 12'h0a4;
localparam logic [11:0] OFF_IRQ = 12'h0a8;

////////////////////////////////////////////////////////////////////////
// port mode field codes
localparam logic [3:0] MODE_SPI_M4 = 4'h0;
localparam logic [3:0] MODE_SPI_M16 = 4'h1;
localparam logic [3:0] MODE_SPI_M64 = 4'h2;
localparam logic [3:0] MODE_SPI_MTMR = 4'h3;
localparam logic [3:0] MODE_SPI_SS = 4'h4;
localparam logic [3:0] MODE_SPI_SLV = 4'h5;
localparam logic [3:0] MODE_I2C_S7 = 4'h6;
localparam logic [3:0] MODE_I2C_S10 = 4'h7;
localparam logic [3:0] MODE_I2C_M = 4'h8;
localparam logic [3:0] MODE_I2C_FW = 4'hb;
localparam logic [3:0] MODE_I2C_S7SP = 4'he;
localparam logic [3:0] MODE_I2C_S10SP = 4'hf;

////////////////////////////////////////////////////////////////////////
// master half bit periods in clk cycles, last bit index
localparam logic [4:0] HALF_DIV4 = 5'h02;
localparam logic [4:0] HALF_DIV16 = 5'h08;
localparam logic [4:0] HALF_DIV64 = 5'h1f;
localparam logic [2:0] BIT_LAST = 3'h7;

////////////////////////////////////////////////////////////////////////
// register layouts
typedef struct packed {
   logic wcol;
   logic ov;
   logic en;
   logic clock_idle_polarity;
   logic [3:0] mode;
} ctrl_t;

typedef struct packed {
   logic sample_or_slew_select;
   logic cke;
   logic d_a;
   logic p;
   logic s;
   logic rw;
   logic ua;
   logic bf;
} status_t;

localparam ctrl_t CTRL_RST = 8'h00;
localparam status_t STATUS_RST = 8'h00;
localparam logic [7:0] REG_RST = 8'h00;
localparam logic [7:0] IRQ_CLR_BIT = 8'h01;

////////////////////////////////////////////////////////////////////////
// carriers
typedef struct packed {
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
} apb_req_t;

typedef struct packed {
   logic start;
   logic stop;
   logic nack;
   logic addr_match;
   logic rw;
   logic byte_done;
   logic is_data;
   logic [7:0] rx_byte;
   logic ua_req;
   logic tx_busy;
   logic seq_done;
} i2c_evt_t;

typedef struct packed {
   logic slew_ctrl_en;
   logic smbus_en;
   logic [7:0] own_addr;
   logic [6:0] baud_reload;
   logic [7:0] tx_byte;
   logic tx_load;
   logic [4:0] requests;
   logic idle;
} i2c_ctl_t;

typedef enum logic {M_IDLE, M_RUN} mst_state_t;

endpackage

//--- hdl/sync_serial_module.sv
`timescale 1ns/1ps
`default_nettype none

module sync_serial_module (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // apb slave
   input wire sync_serial_pkg::apb_req_t apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // spi pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   input wire logic slave_select_n,
   // system side
   input wire logic serial_out_dir_input,
   input wire logic timer_tick,
   input wire logic sleep,
   output logic port_irq_flag,
   // i2c sequencer side
   input wire sync_serial_pkg::i2c_evt_t i2c_evt,
   output sync_serial_pkg::i2c_ctl_t i2c_ctl
);

////////////////////////////////////////////////////////////////////////
sync_serial_pkg::ctrl_t ctrl;
sync_serial_pkg::status_t stat;
sync_serial_pkg::mst_state_t mst;
logic [7:0] ctrl2, addr_reg, buf_reg, sr;
logic [2:0] bitcnt, tcnt;
logic [4:0] div, half;
logic [2:0] s1, s2, s3, st;
logic sck_prev, pend, in_bit, ph, tx_load;
logic spi_mode, spi_master, spi_slave, i2c_on, i2c_master, slave_act;
logic xfer_rst, tick, lead, trail, samp, shft, busy, spi_done, i2c_rx;
logic wr, rd, setup, wr_buf, rd_buf, load_spi, load_i2c;
logic [7:0] rv, rx_byte;

function automatic logic is_i2c(input logic [3:0] m);
   return m inside {sync_serial_pkg::MODE_I2C_S7, sync_serial_pkg::MODE_I2C_S10,
      sync_serial_pkg::MODE_I2C_M, sync_serial_pkg::MODE_I2C_FW,
      sync_serial_pkg::MODE_I2C_S7SP, sync_serial_pkg::MODE_I2C_S10SP};
endfunction

function automatic logic mapped(input logic [11:0] a);
   return a inside {sync_serial_pkg::OFF_STATUS, sync_serial_pkg::OFF_BUF,
      sync_serial_pkg::OFF_CTRL, sync_serial_pkg::OFF_CTRL2,
      sync_serial_pkg::OFF_ADDR, sync_serial_pkg::OFF_IRQ};
endfunction

////////////////////////////////////////////////////////////////////////
// mode decode
assign spi_master = ctrl.en && ctrl.mode <= sync_serial_pkg::MODE_SPI_MTMR;
assign spi_slave = ctrl.en && (ctrl.mode == sync_serial_pkg::MODE_SPI_SS ||
   ctrl.mode == sync_serial_pkg::MODE_SPI_SLV);
assign spi_mode = spi_master || spi_slave;
assign i2c_on = ctrl.en && is_i2c(ctrl.mode);
assign i2c_master = ctrl.mode == sync_serial_pkg::MODE_I2C_M ||
   ctrl.mode == sync_serial_pkg::MODE_I2C_FW;
// select high in select mode or disable resets the transfer
assign xfer_rst = !ctrl.en || (ctrl.mode == sync_serial_pkg::MODE_SPI_SS && st[1]);
assign slave_act = spi_slave && (ctrl.mode == sync_serial_pkg::MODE_SPI_SLV || !st[1]);

////////////////////////////////////////////////////////////////////////
// apb decode
assign setup = apb.psel && !apb.penable;
assign wr = apb.psel && apb.penable && apb.pwrite;
assign rd = apb.psel && apb.penable && !apb.pwrite;
assign wr_buf = wr && apb.paddr == sync_serial_pkg::OFF_BUF;
assign rd_buf = rd && apb.paddr == sync_serial_pkg::OFF_BUF;
assign pready = 1'b1;
assign pslverr = apb.psel && apb.penable && !mapped(apb.paddr);

always_comb begin
   unique case (apb.paddr)
      sync_serial_pkg::OFF_STATUS: rv = stat;
      sync_serial_pkg::OFF_BUF: rv = buf_reg;
      sync_serial_pkg::OFF_CTRL: rv = ctrl;
      sync_serial_pkg::OFF_CTRL2: rv = ctrl2;
      sync_serial_pkg::OFF_ADDR: rv = addr_reg;
      sync_serial_pkg::OFF_IRQ: rv = {7'h00, port_irq_flag};
      default: rv = 8'h00;
   endcase
end

always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      prdata <= 32'h0000_0000;
   end else if (ce && setup && !apb.pwrite) begin
      prdata <= {24'h00_0000, mapped(apb.paddr) ? rv : 8'h00};
   end
end

////////////////////////////////////////////////////////////////////////
// pin synchronisers: sck, select, serial in
always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      s1 <= 3'h2;
      s2 <= 3'h2;
      s3 <= 3'h2;
      st <= 3'h2;
      sck_prev <= 1'b0;
   end else if (ce) begin
      s1 <= {sck_in, slave_select_n, serial_in_pin};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 3; i++) begin
         if (s2[i] == s3[i]) begin
            st[i] <= s2[i];
         end
      end
      sck_prev <= st[2];
   end
end

////////////////////////////////////////////////////////////////////////
// master clock generator
always_comb begin
   unique case (ctrl.mode[1:0])
      2'h0: half = sync_serial_pkg::HALF_DIV4;
      2'h1: half = sync_serial_pkg::HALF_DIV16;
      default: half = sync_serial_pkg::HALF_DIV64;
   endcase
end

assign tick = ctrl.mode == sync_serial_pkg::MODE_SPI_MTMR ? timer_tick : div == half - 5'h01;

always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      mst <= sync_serial_pkg::M_IDLE;
      div <= 5'h00;
      ph <= 1'b0;
      tcnt <= 3'h0;
   end else if (ce) begin
      if (!spi_master) begin
         mst <= sync_serial_pkg::M_IDLE;
         div <= 5'h00;
         ph <= 1'b0;
         tcnt <= 3'h0;
      end else if (!sleep) begin
         unique case (mst)
            sync_serial_pkg::M_IDLE: begin
               div <= 5'h00;
               if (load_spi) begin
                  mst <= sync_serial_pkg::M_RUN;
               end
            end
            sync_serial_pkg::M_RUN: begin
               if (tick) begin
                  div <= 5'h00;
                  ph <= !ph;
                  if (ph) begin
                     tcnt <= tcnt + 3'h1;
                     if (tcnt == sync_serial_pkg::BIT_LAST) begin
                        mst <= sync_serial_pkg::M_IDLE;
                     end
                  end
               end else begin
                  div <= div + 5'h01;
               end
            end
         endcase
      end
   end
end

assign sck_out = ctrl.clock_idle_polarity ^ ph;
assign sck_oe = spi_master;

////////////////////////////////////////////////////////////////////////
// edges: leading leaves idle level, edge bit set samples on leading
always_comb begin
   if (spi_master) begin
      lead = mst == sync_serial_pkg::M_RUN && tick && !sleep && !ph;
      trail = mst == sync_serial_pkg::M_RUN && tick && !sleep && ph;
   end else begin
      lead = slave_act && st[2] != sck_prev && st[2] != ctrl.clock_idle_polarity;
      trail = slave_act && st[2] != sck_prev && st[2] == ctrl.clock_idle_polarity;
   end
end

assign samp = stat.cke ? lead : trail;
assign shft = stat.cke ? trail : lead;
assign busy = spi_master ? mst == sync_serial_pkg::M_RUN : (bitcnt != 3'h0 || pend);
assign load_spi = wr_buf && spi_mode && !busy;
assign load_i2c = wr_buf && i2c_on;
assign spi_done = samp && bitcnt == sync_serial_pkg::BIT_LAST && !xfer_rst;
assign rx_byte = {sr[6:0], st[0]};
assign i2c_rx = i2c_on && i2c_evt.byte_done;

////////////////////////////////////////////////////////////////////////
// shift register and bit counter
always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      sr <= sync_serial_pkg::REG_RST;
      bitcnt <= 3'h0;
      pend <= 1'b0;
      in_bit <= 1'b0;
   end else if (ce) begin
      if (xfer_rst) begin
         bitcnt <= 3'h0;
         pend <= 1'b0;
         // a deselected slave still takes the next byte to send
         if (load_spi) begin
            sr <= apb.pwdata[7:0];
         end
      end else if (load_spi || load_i2c) begin
         sr <= apb.pwdata[7:0];
      end else if (samp) begin
         if (bitcnt == sync_serial_pkg::BIT_LAST) begin
            sr <= rx_byte;
            pend <= 1'b0;
         end else begin
            in_bit <= st[0];
            pend <= 1'b1;
         end
         bitcnt <= bitcnt + 3'h1;
      end else if (shft && pend) begin
         sr <= {sr[6:0], in_bit};
         pend <= 1'b0;
      end
   end
end

assign serial_out_pin = sr[7];
// in select mode drive only while selected, never when the pin is set to input
assign serial_out_oe = spi_mode && !serial_out_dir_input &&
   (ctrl.mode != sync_serial_pkg::MODE_SPI_SS || !st[1]);

////////////////////////////////////////////////////////////////////////
// data buffer, buffer full, overflow, write collision
always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      buf_reg <= sync_serial_pkg::REG_RST;
      stat.bf <= 1'b0;
   end else if (ce) begin
      if (load_spi || load_i2c) begin
         buf_reg <= apb.pwdata[7:0];
      end else if (spi_done && (spi_master || !stat.bf)) begin
         buf_reg <= rx_byte;
      end else if (i2c_rx && !stat.bf) begin
         buf_reg <= i2c_evt.rx_byte;
      end
      if ((spi_done && (spi_master || !stat.bf)) || (i2c_rx && !stat.bf)) begin
         stat.bf <= 1'b1;
      end else if (rd_buf) begin
         stat.bf <= 1'b0;
      end
   end
end

always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      ctrl <= sync_serial_pkg::CTRL_RST;
   end else if (ce) begin
      if (wr && apb.paddr == sync_serial_pkg::OFF_CTRL) begin
         ctrl <= apb.pwdata[7:0];
      end
      if (wr_buf && spi_mode && busy) begin
         ctrl.wcol <= 1'b1;
      end
      if (((spi_done && spi_slave) || i2c_rx) && stat.bf) begin
         ctrl.ov <= 1'b1;
      end
   end
end

always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      port_irq_flag <= 1'b0;
   end else if (ce) begin
      if (spi_done || i2c_rx) begin
         port_irq_flag <= 1'b1;
      end else if (wr && apb.paddr == sync_serial_pkg::OFF_IRQ && apb.pwdata[0]) begin
         port_irq_flag <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// i2c status flags, control 2, address register
always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      {stat.sample_or_slew_select, stat.cke, stat.d_a, stat.p, stat.s, stat.rw, stat.ua} <= 7'h00;
      ctrl2 <= sync_serial_pkg::REG_RST;
      addr_reg <= sync_serial_pkg::REG_RST;
      tx_load <= 1'b0;
   end else if (ce) begin
      tx_load <= load_i2c;
      if (wr && apb.paddr == sync_serial_pkg::OFF_STATUS) begin
         {stat.sample_or_slew_select, stat.cke} <= apb.pwdata[7:6];
      end
      if (wr && apb.paddr == sync_serial_pkg::OFF_ADDR) begin
         addr_reg <= apb.pwdata[7:0];
      end
      if (wr && apb.paddr == sync_serial_pkg::OFF_CTRL2) begin
         ctrl2 <= apb.pwdata[7:0];
      end else if (i2c_on && i2c_evt.seq_done) begin
         {ctrl2[4], ctrl2[2:0]} <= 4'h0;
      end
      if (!i2c_on) begin
         {stat.d_a, stat.p, stat.s, stat.rw} <= 4'h0;
      end else begin
         if (i2c_evt.byte_done) begin
            stat.d_a <= !i2c_master && i2c_evt.is_data;
         end
         if (i2c_evt.stop) begin
            stat.p <= 1'b1;
            stat.s <= 1'b0;
         end else if (i2c_evt.start) begin
            stat.s <= 1'b1;
            stat.p <= 1'b0;
         end
         if (i2c_master) begin
            stat.rw <= i2c_evt.tx_busy;
         end else if (i2c_evt.addr_match) begin
            stat.rw <= i2c_evt.rw;
         end else if (i2c_evt.start || i2c_evt.stop || i2c_evt.nack) begin
            stat.rw <= 1'b0;
         end
      end
      if (i2c_on && i2c_evt.ua_req) begin
         stat.ua <= 1'b1;
      end else if (!i2c_on || (wr && apb.paddr == sync_serial_pkg::OFF_ADDR)) begin
         stat.ua <= 1'b0;
      end
   end
end

assign i2c_ctl.slew_ctrl_en = i2c_on && !stat.sample_or_slew_select;
assign i2c_ctl.smbus_en = i2c_on && stat.cke;
assign i2c_ctl.own_addr = i2c_on && !i2c_master ? addr_reg : 8'h00;
assign i2c_ctl.baud_reload = i2c_on && i2c_master ? addr_reg[6:0] : 7'h00;
assign i2c_ctl.tx_byte = sr;
assign i2c_ctl.tx_load = tx_load;
assign i2c_ctl.requests = ctrl2[4:0];
assign i2c_ctl.idle = !(stat.rw || |ctrl2[4:0]);

////////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);

property p_ss_reset;
   ce && ctrl.en && ctrl.mode == sync_serial_pkg::MODE_SPI_SS && st[1] |=> bitcnt == 3'h0 && !pend;
endproperty
a_ss_reset: assert property (p_ss_reset) else $error("select high did not reset");

property p_dis_reset;
   ce && !ctrl.en |=> bitcnt == 3'h0;
endproperty
a_dis_reset: assert property (p_dis_reset) else $error("disable did not clear counter");

property p_ss_float;
   spi_slave && ctrl.mode == sync_serial_pkg::MODE_SPI_SS && st[1] |-> !serial_out_oe;
endproperty
a_ss_float: assert property (p_ss_float) else $error("output driven while deselected");

property p_sleep_hold;
   ce && spi_master && sleep |=> $stable(ph) && $stable(div) && $stable(sr);
endproperty
a_sleep_hold: assert property (p_sleep_hold) else $error("master moved in sleep");

property p_slave_flag;
   ce && spi_slave && spi_done |=> port_irq_flag && stat.bf;
endproperty
a_slave_flag: assert property (p_slave_flag) else $error("slave byte not flagged");

property p_lead_level;
   ce && spi_master && lead |=> sck_out == !ctrl.clock_idle_polarity;
endproperty
a_lead_level: assert property (p_lead_level) else $error("leading edge level wrong");

property p_dir_in;
   serial_out_dir_input |-> !serial_out_oe;
endproperty
a_dir_in: assert property (p_dir_in) else $error("drove pin set as input");

property p_i2c_rx;
   ce && i2c_rx && !stat.bf && !wr_buf |=> stat.bf && buf_reg == $past(i2c_evt.rx_byte);
endproperty
a_i2c_rx: assert property (p_i2c_rx) else $error("i2c byte not buffered");

property p_i2c_tx;
   ce && load_i2c |=> sr == buf_reg && sr == $past(apb.pwdata[7:0]);
endproperty
a_i2c_tx: assert property (p_i2c_tx) else $error("i2c write not in both");

property p_rd_clear;
   ce && rd_buf && !spi_done && !i2c_rx |=> !stat.bf;
endproperty
a_rd_clear: assert property (p_rd_clear) else $error("read kept buffer full");

c_master_byte: cover property (spi_master && spi_done);
c_slave_byte: cover property (spi_slave && spi_done && sleep);
c_i2c_rx: cover property (i2c_rx && !stat.bf);

endmodule

`default_nettype wire

//--- testbench/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
   // clock
   input wire logic clk,
   // lines from the device
   input wire logic serial_out_pin,
   input wire logic serial_out_oe,
   // lines to the device
   output logic sck,
   output logic sel_n,
   output wire logic mosi
);
   logic data_bit = 1'b0;
   logic junk = 1'b0;
   logic miso_wire;

   initial begin
      sck = 1'b0;
      sel_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // released lines show a pattern that changes every cycle
   always @(posedge clk) begin
      junk <= ~junk;
   end
   assign mosi = sel_n ? junk : data_bit;
   assign miso_wire = serial_out_oe ? serial_out_pin : junk;

   ////////////////////////////////////////////////////////////////////////
   // select, then let the synchroniser settle
   task automatic select(input logic on);
      @(posedge clk);
      sel_n <= ~on;
      repeat (8) @(posedge clk);
   endtask

   // clock idles low, data set while low, sampled on rising edge, msb first
   task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         @(posedge clk);
         data_bit <= tx[7 - i];
         repeat (8) @(posedge clk);
         sck <= 1'b1;
         rx = {rx[6:0], miso_wire};
         repeat (8) @(posedge clk);
         sck <= 1'b0;
      end
   endtask
endmodule

`default_nettype wire

//--- testbench/tb_sync_serial_port_spi_i2c.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sync_serial_port_spi_i2c;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   sync_serial_pkg::apb_req_t apb = '0;
   sync_serial_pkg::i2c_evt_t evt = '0;
   sync_serial_pkg::i2c_ctl_t ctl;
   logic [31:0] prdata;
   logic pready, pslverr, sck_out, sck_oe, sout, sout_oe, sck, sel_n, mosi, irq;
   logic ce = 1'b1;
   logic dir_in = 1'b0;
   logic tick = 1'b0;
   logic sleep = 1'b0;
   logic sck_q = 1'b0;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int edges = 0;
   int tprev = 0;
   int tlast = 0;
   int tcnt = 0;
   logic [31:0] rd;
   logic [7:0] rx;
   logic err;

   sync_serial_module dut (.clk(clk), .rstn(rstn), .ce(ce), .apb(apb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .serial_in_pin(mosi),
      .serial_out_pin(sout), .serial_out_oe(sout_oe), .slave_select_n(sel_n), .serial_out_dir_input(dir_in),
      .timer_tick(tick), .sleep(sleep), .port_irq_flag(irq), .i2c_evt(evt), .i2c_ctl(ctl));
   spi_master_model spi (.clk(clk), .serial_out_pin(sout), .serial_out_oe(sout_oe), .sck(sck),
      .sel_n(sel_n), .mosi(mosi));

   initial begin
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // timer pulse every 5 cycles, clock edge monitor, timeout
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
      tick <= (tcnt == 4);
      sck_q <= sck_out;
      if (sck_out === 1'b1 && sck_q === 1'b0) begin
         edges <= edges + 1;
         tprev <= tlast;
         tlast <= cyc;
      end
      if (cyc == 40000) begin
         err_total++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb_xfer(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: a, pwdata: d};
      @(posedge clk);
      apb.penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      apb <= '0;
      if (n == 50) chk("pready", 0, 1);
      @(negedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb_xfer(1'b1, a, {24'h000000, d});
   endtask

   task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] mask, input logic [7:0] exp);
      apb_xfer(1'b0, a, 32'h00000000);
      chk(what, rd & {24'h000000, mask}, {24'h000000, exp});
   endtask

   task automatic pulse(input sync_serial_pkg::i2c_evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      repeat (2) @(posedge clk);
   endtask

   task automatic master_byte(input logic [3:0] m);
      int per;
      int e0;
      int n;
      per = (m == 0) ? 2 * sync_serial_pkg::HALF_DIV4 : (m == 1) ? 2 * sync_serial_pkg::HALF_DIV16 :
         (m == 2) ? 2 * sync_serial_pkg::HALF_DIV64 : 10;
      wr(sync_serial_pkg::OFF_CTRL, {4'h2, m});
      e0 = edges;
      wr(sync_serial_pkg::OFF_BUF, 8'h5a);
      if (m == sync_serial_pkg::MODE_SPI_M64) begin
         repeat (100) @(posedge clk);
         sleep <= 1'b1;
         repeat (3) @(posedge clk);
         n = edges;
         repeat (200) @(posedge clk);
         chk("edges in sleep", edges - n, 0);
         sleep <= 1'b0;
      end
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         n++;
         @(posedge clk);
      end
      chk("clock edges", edges - e0, 8);
      chk("bit period", tlast - tprev, per);
      chk("clock idle", sck_out, 1'b0);
      chk("clock drive", sck_oe, 1'b1);
      apb_xfer(1'b0, sync_serial_pkg::OFF_BUF, 32'h00000000);
      wr(sync_serial_pkg::OFF_IRQ, sync_serial_pkg::IRQ_CLR_BIT);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      // reset values, read-only status bits, unmapped place
      rdc("status", sync_serial_pkg::OFF_STATUS, 8'hff, 8'h00);
      rdc("control", sync_serial_pkg::OFF_CTRL, 8'hff, 8'h00);
      apb_xfer(1'b0, 12'h0fc, 32'h00000000);
      chk("slverr", err, 1'b1);
      wr(sync_serial_pkg::OFF_STATUS, 8'hff);
      rdc("status rw", sync_serial_pkg::OFF_STATUS, 8'hff, 8'hc0);
      wr(sync_serial_pkg::OFF_STATUS, 8'h40);
      $display("test registers done");
      // slave with select control, full byte
      wr(sync_serial_pkg::OFF_CTRL, 8'h24);
      wr(sync_serial_pkg::OFF_BUF, 8'ha5);
      chk("out enable idle", sout_oe, 1'b0);
      spi.select(1'b1);
      chk("out enable", sout_oe, 1'b1);
      spi.shift(8'h3c, 8, rx);
      chk("slave tx", rx, 8'ha5);
      spi.select(1'b0);
      chk("out float", sout_oe, 1'b0);
      chk("irq", irq, 1'b1);
      rdc("full", sync_serial_pkg::OFF_STATUS, 8'h01, 8'h01);
      rdc("rx byte", sync_serial_pkg::OFF_BUF, 8'hff, 8'h3c);
      rdc("empty", sync_serial_pkg::OFF_STATUS, 8'h01, 8'h00);
      wr(sync_serial_pkg::OFF_IRQ, sync_serial_pkg::IRQ_CLR_BIT);
      chk("irq clear", irq, 1'b0);
      // select taken high mid byte, then a byte while sleeping
      wr(sync_serial_pkg::OFF_BUF, 8'hc3);
      spi.select(1'b1);
      spi.shift(8'hff, 3, rx);
      spi.select(1'b0);
      chk("float mid byte", sout_oe, 1'b0);
      spi.select(1'b1);
      sleep <= 1'b1;
      spi.shift(8'h81, 8, rx);
      sleep <= 1'b0;
      chk("irq in sleep", irq, 1'b1);
      rdc("after resync", sync_serial_pkg::OFF_BUF, 8'hff, 8'h81);
      wr(sync_serial_pkg::OFF_IRQ, sync_serial_pkg::IRQ_CLR_BIT);
      // disable mid byte resets the bit counter
      spi.shift(8'hff, 4, rx);
      wr(sync_serial_pkg::OFF_CTRL, 8'h04);
      wr(sync_serial_pkg::OFF_CTRL, 8'h24);
      spi.shift(8'h96, 8, rx);
      rdc("after disable", sync_serial_pkg::OFF_BUF, 8'hff, 8'h96);
      spi.select(1'b0);
      // output pin set to input
      dir_in <= 1'b1;
      spi.select(1'b1);
      chk("receive only", sout_oe, 1'b0);
      dir_in <= 1'b0;
      // device reset mid byte
      spi.shift(8'hff, 4, rx);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdc("control after reset", sync_serial_pkg::OFF_CTRL, 8'hff, 8'h00);
      chk("out after reset", sout_oe, 1'b0);
      spi.select(1'b0);
      $display("test spi slave done");
      for (int m = 0; m < 4; m++) begin
         master_byte(4'(m));
      end
      $display("test spi master done");
      // i2c seven-bit slave
      wr(sync_serial_pkg::OFF_CTRL, 8'h26);
      wr(sync_serial_pkg::OFF_STATUS, 8'h40);
      wr(sync_serial_pkg::OFF_ADDR, 8'ha4);
      chk("own address", ctl.own_addr, 8'ha4);
      chk("slew on", ctl.slew_ctrl_en, 1'b1);
      chk("smbus on", ctl.smbus_en, 1'b1);
      // clock enable low freezes every register
      @(posedge clk);
      ce <= 1'b0;
      wr(sync_serial_pkg::OFF_ADDR, 8'h11);
      @(posedge clk);
      ce <= 1'b1;
      rdc("frozen address", sync_serial_pkg::OFF_ADDR, 8'hff, 8'ha4);
      pulse('{start: 1'b1, default: '0});
      pulse('{addr_match: 1'b1, rw: 1'b1, default: '0});
      pulse('{byte_done: 1'b1, is_data: 1'b1, rx_byte: 8'h77, default: '0});
      rdc("i2c status", sync_serial_pkg::OFF_STATUS, 8'hff, 8'h6d);
      chk("i2c irq", irq, 1'b1);
      rdc("i2c rx", sync_serial_pkg::OFF_BUF, 8'hff, 8'h77);
      wr(sync_serial_pkg::OFF_BUF, 8'h3e);
      chk("tx load", ctl.tx_load, 1'b1);
      repeat (2) @(posedge clk);
      chk("tx shifter", ctl.tx_byte, 8'h3e);
      chk("tx load end", ctl.tx_load, 1'b0);
      pulse('{stop: 1'b1, default: '0});
      rdc("stop seen", sync_serial_pkg::OFF_STATUS, 8'h18, 8'h10);
      wr(sync_serial_pkg::OFF_CTRL, 8'h06);
      rdc("flags disabled", sync_serial_pkg::OFF_STATUS, 8'h18, 8'h00);
      wr(sync_serial_pkg::OFF_STATUS, 8'h80);
      // ten-bit slave, then master
      wr(sync_serial_pkg::OFF_CTRL, 8'h27);
      chk("slew off", ctl.slew_ctrl_en, 1'b0);
      chk("smbus off", ctl.smbus_en, 1'b0);
      pulse('{ua_req: 1'b1, default: '0});
      rdc("address update", sync_serial_pkg::OFF_STATUS, 8'h02, 8'h02);
      pulse('{addr_match: 1'b1, rw: 1'b1, default: '0});
      pulse('{nack: 1'b1, default: '0});
      rdc("nack clears rw", sync_serial_pkg::OFF_STATUS, 8'h04, 8'h00);
      wr(sync_serial_pkg::OFF_CTRL, 8'h28);
      wr(sync_serial_pkg::OFF_ADDR, 8'hc5);
      chk("baud reload", ctl.baud_reload, 7'h45);
      chk("no own address", ctl.own_addr, 8'h00);
      wr(sync_serial_pkg::OFF_CTRL2, 8'h1f);
      chk("requests", ctl.requests, 5'h1f);
      chk("requests busy", ctl.idle, 1'b0);
      pulse('{seq_done: 1'b1, default: '0});
      rdc("auto clear", sync_serial_pkg::OFF_CTRL2, 8'hff, 8'h08);
      wr(sync_serial_pkg::OFF_CTRL2, 8'h00);
      @(posedge clk);
      evt <= '{tx_busy: 1'b1, default: '0};
      rdc("tx busy", sync_serial_pkg::OFF_STATUS, 8'h04, 8'h04);
      chk("busy", ctl.idle, 1'b0);
      @(posedge clk);
      evt <= '0;
      repeat (3) @(posedge clk);
      chk("idle", ctl.idle, 1'b1);
      $display("test i2c done");
      test_done();
   end
endmodule

`default_nettype wire
